// [design/line_ctrl_pkg.sv]
// Constants and carrier types for the line controller time base
// Assumes a 100 MHz system clock; all window times are in microseconds
package line_ctrl_pkg;
  // ----------------------------------------------------------------
  // Clock and time conversion
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int US_NS         = 1000;
  localparam int US_CYCLES     = US_NS / CLK_PERIOD_NS;
  localparam int DL_NS         = 100;
  localparam int DL_CYCLES     = DL_NS / CLK_PERIOD_NS;
  // ----------------------------------------------------------------
  // Time base points in microseconds after cycle sync, then intervals in microseconds, counts and the sync byte
  // ----------------------------------------------------------------
  localparam int POLL_START_US = 1024;
  localparam int CMD_START_US  = 28952;
  localparam int CMD_END_US    = 49456;
  localparam int BENCH_SYNC_US = 52224;
  localparam int RESP_US       = 58;
  localparam int MON_CLR_AT    = 55;
  localparam int STROBE_US     = 80;
  localparam int PRESENT_US    = 16;
  localparam int CLR_US        = 5;
  localparam int POLL_TOTAL    = 384;
  localparam int XFER_MAX      = 3;
  localparam logic [7:0] SYNC_BYTE = 8'hAA;
  // ----------------------------------------------------------------
  // Register map (word aligned byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_ADDR   = 8'h00;
  localparam logic [7:0] STATUS_ADDR = 8'h04;
  localparam logic [7:0] TIME_ADDR   = 8'h08;
  localparam logic [7:0] POLL_ADDR   = 8'h0C;
  localparam logic [7:0] TRIP_ADDR   = 8'h10;
  localparam logic [2:0] CTRL_RESET  = 3'h6;
  localparam int CTRL_BENCH_BIT = 0;
  localparam int CTRL_POLL_BIT  = 1;
  localparam int CTRL_CMD_BIT   = 2;
  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        ack;
    logic [15:0] data;
  } host_in_t;
  typedef struct packed {
    logic [7:0]  low_byte;
    logic [15:0] second;
    logic [15:0] third;
  } cmd_word_t;
  typedef struct packed {
    logic [15:0] word;
    logic [2:0]  data_set;
    logic        second;
  } mon_out_t;
endpackage

// [design/line_ctrl_timebase_cmd_fetch.sv]
// Time base, monitor poll sequencer and command triplet fetch
// Assumes synchronous inputs, a Wishbone classic master, two hosts
`timescale 1ns/1ns
module line_ctrl_timebase_cmd_fetch
  import line_ctrl_pkg::*;
#(
  parameter int US_CYC   = US_CYCLES,
  parameter int DL_CYC   = DL_CYCLES,
  parameter int POLL_ST  = POLL_START_US,
  parameter int CMD_ST   = CMD_START_US,
  parameter int CMD_END  = CMD_END_US,
  parameter int BENCH_AT = BENCH_SYNC_US
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        cycle_sync_pulse_i,
  input  wire host_in_t    host_a_i,
  input  wire host_in_t    host_b_i,
  output logic      [1:0]  host_req_o,
  output logic             host_sel_o,
  input  wire logic [15:0] mon_word_i,
  input  wire logic        mon_valid_i,
  output cmd_word_t        cmd_o,
  output logic             first_word_load_strobe_o,
  output logic             second_word_load_strobe_o,
  output logic             third_word_load_strobe_o,
  output logic             start_char_load_o,
  output logic             query_o,
  output logic             mon_buf_clear_o,
  output logic      [4:0]  buffer_station_address_o,
  output mon_out_t         mon_out_o,
  output logic             mon_present_o,
  output logic             cmd_mode_o,
  output logic             poll_mode_o,
  output logic             clk2_o,
  output logic             clk1_o,
  output logic             svc_int_o
);
  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [6:0]  presc_reg;
  logic [3:0]  dl_presc_reg;
  logic [15:0] tb_reg;
  logic [2:0]  clr_cnt_reg;
  logic        sync_prev_reg;
  logic        clr_reg;
  logic        cmd_mode_reg;
  logic        poll_mode_reg;
  logic [6:0]  s80_cnt_reg;
  logic        host_sel_reg;
  logic [1:0]  req_flag_reg;
  logic [5:0]  resp_cnt_reg;
  logic [8:0]  poll_cnt_reg;
  logic [3:0]  pres_cnt_reg;
  logic [15:0] mon_buf_reg;
  logic [2:0]  dl_reg;
  logic [3:0]  tok_reg;
  logic [1:0]  xfer_cnt_reg;
  logic        det_en_reg;
  logic [2:0]  ctrl_reg;
  logic [15:0] trip_cnt_reg;
  logic        ack_reg;
  logic        tick_us;
  logic        tick_dl;
  logic        sync_edge;
  logic        bench_sync;
  logic        clr_start;
  logic        strobe80;
  logic        load_start;
  logic        resp_tc;
  logic        ack_sel;
  logic [15:0] data_sel;
  logic        tok_clk;
  logic        match;
  logic        first_ld;
  logic        second_ld;
  logic        third_ld;
  logic        tok_end;
  logic        wb_req;

  // ----------------------------------------------------------------
  // Time base
  // ----------------------------------------------------------------
  assign tick_us    = (presc_reg == 7'(US_CYC - 1));
  assign tick_dl    = (dl_presc_reg == 4'(DL_CYC - 1));
  assign sync_edge  = cycle_sync_pulse_i & ~sync_prev_reg;
  assign bench_sync = ctrl_reg[CTRL_BENCH_BIT] & tick_us &
                      (tb_reg == 16'(BENCH_AT - 1));
  assign clr_start  = sync_edge | bench_sync;

  // Microsecond prescaler, restarted at the sync so phase is fixed;
  // it keeps running in clear, else the stretcher could never time out
  always_ff @(posedge clk_i) begin
    if (rst_i || clr_start || tick_us) begin
      presc_reg <= 7'h00;
    end else begin
      presc_reg <= presc_reg + 7'h01;
    end
  end

  // 10 MHz sampling divider for the acknowledge delay line
  always_ff @(posedge clk_i) begin
    if (rst_i || tick_dl) begin
      dl_presc_reg <= 4'h0;
    end else begin
      dl_presc_reg <= dl_presc_reg + 4'h1;
    end
  end

  // Sync edge detect; the input is already synchronous
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync_prev_reg <= 1'b0;
    end else begin
      sync_prev_reg <= cycle_sync_pulse_i;
    end
  end

  // Clear stretcher: a wide clear is harmless and rides out bounce
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clr_reg     <= 1'b0;
      clr_cnt_reg <= 3'h0;
    end else if (clr_start) begin
      clr_reg     <= 1'b1;
      clr_cnt_reg <= 3'h0;
    end else if (clr_reg && tick_us) begin
      clr_cnt_reg <= clr_cnt_reg + 3'h1;
      if (clr_cnt_reg == 3'(CLR_US - 1)) begin
        clr_reg <= 1'b0;
      end
    end
  end

  // Microsecond counter of the machine cycle
  always_ff @(posedge clk_i) begin
    if (rst_i || clr_reg) begin
      tb_reg <= 16'h0000;
    end else if (tick_us) begin
      tb_reg <= tb_reg + 16'h0001;
    end
  end

  // Derived clocks; 1 MHz and 2 MHz, split at the half and quarter counts of the microsecond prescaler
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clk1_o <= 1'b0;
      clk2_o <= 1'b0;
    end else begin
      clk1_o <= (presc_reg < 7'(US_CYC / 2));
      clk2_o <= (presc_reg < 7'(US_CYC / 4)) ||
                ((presc_reg >= 7'(US_CYC / 2)) &&
                 (presc_reg < 7'(3 * US_CYC / 4)));
    end
  end

  // ----------------------------------------------------------------
  // Command window and host alternation
  // ----------------------------------------------------------------
  assign strobe80   = cmd_mode_reg & tick_us &
                      (s80_cnt_reg == 7'(STROBE_US - 1));
  // The bench substitute sync stands in for the real one here too
  assign load_start = strobe80 | clr_start;

  // Command mode flag from time decode, dropped on every clear
  always_ff @(posedge clk_i) begin
    if (rst_i || clr_reg) begin
      cmd_mode_reg <= 1'b0;
    end else if (tick_us && tb_reg == 16'(CMD_END - 1)) begin
      cmd_mode_reg <= 1'b0;
    end else if (tick_us && tb_reg == 16'(CMD_ST - 1)) begin
      cmd_mode_reg <= ctrl_reg[CTRL_CMD_BIT];
    end
  end

  // 80 us interval counter, idle outside the command window
  always_ff @(posedge clk_i) begin
    if (rst_i || !cmd_mode_reg || strobe80) begin
      s80_cnt_reg <= 7'h00;
    end else if (tick_us) begin
      s80_cnt_reg <= s80_cnt_reg + 7'h01;
    end
  end

  // Host select toggles on each strobe, so each host waits 160 us
  always_ff @(posedge clk_i) begin
    if (rst_i || clr_reg) begin
      host_sel_reg <= 1'b0;
    end else if (strobe80) begin
      host_sel_reg <= ~host_sel_reg;
    end
  end

  // ----------------------------------------------------------------
  // Command word handshake and triplet capture
  // ----------------------------------------------------------------
  assign ack_sel  = host_sel_reg ? host_b_i.ack  : host_a_i.ack;
  assign data_sel = host_sel_reg ? host_b_i.data : host_a_i.data;
  // Token clock: second one enters the delay line
  assign tok_clk  = tick_dl & ack_sel & dl_reg[0] & ~dl_reg[1];
  assign match    = det_en_reg & (data_sel[15:8] == SYNC_BYTE) &
                    req_flag_reg[host_sel_reg];
  assign first_ld  = tok_clk & match & tok_reg[0];
  assign second_ld = tok_clk & tok_reg[1];
  assign third_ld  = tok_clk & tok_reg[2];
  assign tok_end   = tok_reg[3] |
                     (tok_clk & tok_reg[0] & ~match &
                      (xfer_cnt_reg == 2'(XFER_MAX - 1)));

  // Delay line of the selected host's acknowledge at 10 MHz
  always_ff @(posedge clk_i) begin
    if (rst_i || load_start) begin
      dl_reg <= 3'h0;
    end else if (tick_dl) begin
      dl_reg <= {dl_reg[1:0], ack_sel};
    end
  end

  // Commutating token; armed at stage one by the start load, it walks
  // one stage per word so the third load lands it on the fourth stage
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tok_reg <= 4'h0;
    end else if (load_start) begin
      tok_reg <= 4'h1;
    end else if (tok_reg[3]) begin
      tok_reg <= 4'h0;
    end else if (first_ld || second_ld || third_ld) begin
      tok_reg <= {tok_reg[2:0], 1'b0};
    end
  end

  // Transfers of one attempt, so an empty buffer is not drained
  always_ff @(posedge clk_i) begin
    if (rst_i || load_start) begin
      xfer_cnt_reg <= 2'h0;
    end else if (tok_clk && xfer_cnt_reg != 2'(XFER_MAX)) begin
      xfer_cnt_reg <= xfer_cnt_reg + 2'h1;
    end
  end

  // Pattern detector enable
  always_ff @(posedge clk_i) begin
    if (rst_i || load_start) begin
      det_en_reg <= 1'b1;
    end else if (first_ld) begin
      det_en_reg <= 1'b0;
    end else if (third_ld) begin
      det_en_reg <= 1'b1;
    end
  end

  // Per host request flags, raised on that host's turn
  for (genvar h = 0; h < 2; h++) begin : g_host
    always_ff @(posedge clk_i) begin
      if (rst_i || clr_reg || !cmd_mode_reg) begin
        req_flag_reg[h] <= 1'b0;
      end else if (load_start) begin
        req_flag_reg[h] <= (h == 1) ? ~host_sel_reg :
                                      host_sel_reg;
      end else if (tok_end && host_sel_reg == 1'(h)) begin
        req_flag_reg[h] <= 1'b0;
      end
    end
    // Request withdrawn while the third delay stage holds a one; the
    // window gate stops a strobe at the closing tick from leaking out
    assign host_req_o[h] = req_flag_reg[h] & ~dl_reg[2] &
                           cmd_mode_reg;
  end

  // Command output registers; the host's data is stable at ack
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmd_o <= '0;
    end else begin
      if (first_ld) begin
        cmd_o.low_byte <= data_sel[7:0];
      end
      if (second_ld) begin
        cmd_o.second <= data_sel;
      end
      if (third_ld) begin
        cmd_o.third <= data_sel;
      end
    end
  end

  // One-cycle strobes registered from the load terms
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      first_word_load_strobe_o  <= 1'b0;
      second_word_load_strobe_o <= 1'b0;
      third_word_load_strobe_o  <= 1'b0;
      start_char_load_o         <= 1'b0;
    end else begin
      first_word_load_strobe_o  <= first_ld;
      second_word_load_strobe_o <= second_ld;
      third_word_load_strobe_o  <= third_ld;
      start_char_load_o         <= load_start;
    end
  end

  // ----------------------------------------------------------------
  // Monitor polling
  // ----------------------------------------------------------------
  assign resp_tc = poll_mode_reg & tick_us &
                   (resp_cnt_reg == 6'(RESP_US - 1));

  // Poll window flag
  always_ff @(posedge clk_i) begin
    if (rst_i || clr_reg) begin
      poll_mode_reg <= 1'b0;
    end else if (resp_tc && poll_cnt_reg == 9'(POLL_TOTAL - 1)) begin
      poll_mode_reg <= 1'b0;
    end else if (tick_us && tb_reg == 16'(POLL_ST - 1)) begin
      poll_mode_reg <= ctrl_reg[CTRL_POLL_BIT];
    end
  end

  // 58 us response period counter
  always_ff @(posedge clk_i) begin
    if (rst_i || !poll_mode_reg || resp_tc) begin
      resp_cnt_reg <= 6'h00;
    end else if (tick_us) begin
      resp_cnt_reg <= resp_cnt_reg + 6'h01;
    end
  end

  // Poll sequence counter: low five bits station, high bits pass
  always_ff @(posedge clk_i) begin
    if (rst_i || clr_reg) begin
      poll_cnt_reg <= 9'h000;
    end else if (resp_tc) begin
      poll_cnt_reg <= poll_cnt_reg + 9'h001;
    end
  end

  // Monitor buffer, cleared so that a silent station reads zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mon_buf_reg <= 16'h0000;
    end else if (poll_mode_reg && tick_us &&
                 resp_cnt_reg == 6'(MON_CLR_AT - 1)) begin
      mon_buf_reg <= 16'h0000;
    end else if (mon_valid_i) begin
      mon_buf_reg <= mon_word_i;
    end
  end

  // 16 us presentation interval within the poll window
  always_ff @(posedge clk_i) begin
    if (rst_i || !poll_mode_reg) begin
      pres_cnt_reg <= 4'h0;
    end else if (tick_us) begin
      pres_cnt_reg <= pres_cnt_reg + 4'h1;
    end
  end

  // Poll side outputs; pass index maps onto data set and word
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      query_o                  <= 1'b0;
      mon_buf_clear_o          <= 1'b0;
      buffer_station_address_o <= 5'h00;
      mon_out_o                <= '0;
      mon_present_o            <= 1'b0;
    end else begin
      // Tick lands in the 1 MHz low phase, two cycles before clk1_o rises
      query_o <= resp_tc & ~clk1_o;
      mon_buf_clear_o <= poll_mode_reg & tick_us &
                         (resp_cnt_reg == 6'(MON_CLR_AT - 1));
      buffer_station_address_o <= poll_cnt_reg[4:0];
      mon_present_o <= poll_mode_reg & tick_us &
                       (pres_cnt_reg == 4'(PRESENT_US - 1));
      if (poll_mode_reg && tick_us &&
          pres_cnt_reg == 4'(PRESENT_US - 1)) begin
        mon_out_o.word <= mon_buf_reg;
        if (poll_cnt_reg[8:5] < 4'h5) begin
          mon_out_o.data_set <= 3'(poll_cnt_reg[8:5]);
          mon_out_o.second   <= 1'b0;
        end else if (poll_cnt_reg[8:5] < 4'hA) begin
          mon_out_o.data_set <= 3'(poll_cnt_reg[8:5] - 4'h5);
          mon_out_o.second   <= 1'b1;
        end else begin
          mon_out_o.data_set <= 3'h5;
          mon_out_o.second   <= poll_cnt_reg[5];
        end
      end
    end
  end

  // Service pulse as each window closes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      svc_int_o <= 1'b0;
    end else begin
      svc_int_o <= (tick_us & cmd_mode_reg &
                    (tb_reg == 16'(CMD_END - 1))) |
                   (resp_tc &
                    (poll_cnt_reg == 9'(POLL_TOTAL - 1)));
    end
  end

  // Triplets captured since reset, for software
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      trip_cnt_reg <= 16'h0000;
    end else if (third_ld) begin
      trip_cnt_reg <= trip_cnt_reg + 16'h0001;
    end
  end

  assign host_sel_o  = host_sel_reg;
  assign cmd_mode_o  = cmd_mode_reg;
  assign poll_mode_o = poll_mode_reg;

  // ----------------------------------------------------------------
  // Wishbone slave
  // ----------------------------------------------------------------
  assign wb_req   = wb_cyc_i & wb_stb_i & ~ack_reg;
  assign wb_ack_o = ack_reg;

  // Ack one cycle after the request; writes land at that edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= wb_req;
    end
  end

  // Control register: bench sync, poll enable, command enable
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_reg <= CTRL_RESET;
    end else if (wb_req && wb_we_i && wb_sel_i[0] &&
                 wb_adr_i == CTRL_ADDR) begin
      ctrl_reg <= wb_dat_i[2:0];
    end
  end

  // Read mux; unmapped addresses read zero and still ack
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (wb_req && !wb_we_i) begin
      unique case (wb_adr_i)
        CTRL_ADDR:   wb_dat_o <= {29'h0, ctrl_reg};
        STATUS_ADDR: wb_dat_o <= {26'h0, det_en_reg, req_flag_reg,
                                  host_sel_reg, poll_mode_reg,
                                  cmd_mode_reg};
        TIME_ADDR:   wb_dat_o <= {16'h0, tb_reg};
        POLL_ADDR:   wb_dat_o <= {23'h0, poll_cnt_reg};
        TRIP_ADDR:   wb_dat_o <= {16'h0, trip_cnt_reg};
        default:     wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end
endmodule // line_ctrl_timebase_cmd_fetch

// [verification/line_ctrl_checker.sv]
// Port-level checker for the time base and command fetch block
// Assumes one clock domain and the synchronous active-high reset
`timescale 1ns/1ns
module line_ctrl_checker
  import line_ctrl_pkg::*;
#(
  parameter int DL_CYC = 10
) (
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       wb_ack_o,
  input wire host_in_t   host_a_i,
  input wire logic [1:0] host_req_o,
  input wire logic       host_sel_o,
  input wire logic       query_o,
  input wire logic       poll_mode_o,
  input wire logic       cmd_mode_o,
  input wire logic       svc_int_o,
  input wire logic       start_char_load_o,
  input wire logic       first_word_load_strobe_o,
  input wire logic       second_word_load_strobe_o,
  input wire logic       third_word_load_strobe_o,
  input wire cmd_word_t  cmd_o
);
  localparam int DROP_MAX = 4 * DL_CYC + 2;
  logic [1:0] stage_reg;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Tracks which word load is due next; start load rearms
  always_ff @(posedge clk_i) begin
    if (rst_i || start_char_load_o || third_word_load_strobe_o) stage_reg <= 2'h0;
    else if (first_word_load_strobe_o) stage_reg <= 2'h1;
    else if (second_word_load_strobe_o) stage_reg <= 2'h2;
  end
  // ----
  // Properties
  // ----
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
  a_query_poll: assert property (query_o |-> poll_mode_o) else $error("query outside poll window");
  a_req_window: assert property (|host_req_o |-> cmd_mode_o) else $error("request outside window");
  a_req_sel: assert property (|host_req_o |-> host_req_o == (host_sel_o ? 2'h2 : 2'h1))
    else $error("request to unselected host");
  a_req_drop: assert property (host_a_i.ack && host_req_o[0] |-> ##[1:DROP_MAX] !host_req_o[0])
    else $error("request not withdrawn");
  a_first_rearm: assert property (first_word_load_strobe_o |-> stage_reg == 2'h0)
    else $error("sync detector retriggered");
  a_load_order: assert property (second_word_load_strobe_o |-> stage_reg == 2'h1)
    else $error("second load out of order");
  a_third_order: assert property (third_word_load_strobe_o |-> stage_reg == 2'h2)
    else $error("third load out of order");
  a_third_load: assert property ($changed(cmd_o.third) |-> third_word_load_strobe_o)
    else $error("third word changed without strobe");
  a_svc_end: assert property ($fell(cmd_mode_o) |-> ##[0:2] svc_int_o) else $error("no service pulse");
  a_sel_start: assert property ($changed(host_sel_o) |->
    (start_char_load_o || $past(start_char_load_o) || $past(start_char_load_o, 2)) or ##[1:2] start_char_load_o)
    else $error("host toggle without start load");
  c_first: cover property (first_word_load_strobe_o);
  c_query: cover property (query_o);
  c_svc: cover property (svc_int_o);
  c_start: cover property (start_char_load_o);
endmodule // line_ctrl_checker
bind line_ctrl_timebase_cmd_fetch line_ctrl_checker #(.DL_CYC(DL_CYC)) chk (.*);

// [verification/host_model.sv]
// Behavioural host: answers word requests from a small command buffer
// Expects the block's request level; drives ack and data back
`timescale 1ns/1ns
module host_model
  import line_ctrl_pkg::*;
#(
  parameter int          LAG = 2,
  parameter logic [15:0] W0  = 16'hAA00,
  parameter logic [15:0] W1  = 16'h0000,
  parameter logic [15:0] W2  = 16'h0000
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic req_i,
  output host_in_t  host_o
);
  int idx, wait_c;
  // Past the triplet the buffer memory reads as cleared
  function automatic logic [15:0] word(input int i);
    return (i == 0) ? W0 : (i == 1) ? W1 : (i == 2) ? W2 : 16'h0000;
  endfunction
  // Data leads ack by LAG cycles; ack falls once request drops
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      host_o <= '0;
      idx <= 0;
      wait_c <= 0;
    end else if (req_i && !host_o.ack) begin
      wait_c <= wait_c + 1;
      if (wait_c == 0) host_o.data <= word(idx);
      if (wait_c == LAG) host_o.ack <= 1'b1;
    end else if (!req_i && host_o.ack) begin
      host_o.ack <= 1'b0;
      host_o.data <= ~host_o.data; // Released lines must not show the old word
      idx <= idx + 1;
      wait_c <= 0;
    end else if (!req_i) wait_c <= 0;
  end
endmodule // host_model

// [verification/tb.sv]
// Self-checking bench for the time base and command fetch block
// Drives Wishbone and cycle sync; two host models answer requests
`timescale 1ns/1ns
module tb;
  import line_ctrl_pkg::*;
  localparam int US = 10, DL = 2, PST = 100, CST = 1200, CEN = 1600, BAT = 1800;
  logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, cycle_sync_pulse_i = 0, mon_valid_i = 0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hF;
  logic [15:0] mon_word_i = 16'h0000;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
  logic [1:0] host_req_o;
  logic [4:0] buffer_station_address_o, sta;
  logic host_sel_o, wb_ack_o, first_word_load_strobe_o, second_word_load_strobe_o, third_word_load_strobe_o;
  logic start_char_load_o, query_o, mon_buf_clear_o, mon_present_o, cmd_mode_o, poll_mode_o, clk2_o, clk1_o, svc_int_o;
  logic s, prev;
  host_in_t host_a_i, host_b_i;
  cmd_word_t cmd_o;
  mon_out_t mon_out_o;
  int miscompares = 0, checks = 0, cyc_n = 0;
  time t0, t1;
  line_ctrl_timebase_cmd_fetch #(.US_CYC(US), .DL_CYC(DL), .POLL_ST(PST), .CMD_ST(CST), .CMD_END(CEN),
    .BENCH_AT(BAT)) dut (.*);
  host_model #(.LAG(2), .W0(16'hAA5A), .W1(16'h1357), .W2(16'h2468)) host_a (.clk_i, .rst_i,
    .req_i(host_req_o[0]), .host_o(host_a_i));
  host_model #(.LAG(9), .W0(16'hAAC3), .W1(16'h0F0F), .W2(16'hF0F0)) host_b (.clk_i, .rst_i,
    .req_i(host_req_o[1]), .host_o(host_b_i));
  // ----
  // Clock, timeout and shared tasks
  // ----
  initial forever #5 clk_i = ~clk_i;
  // Whole run is under 20000 cycles; the ceiling leaves margin
  always @(posedge clk_i) begin
    cyc_n++;
    if (cyc_n == 25000) begin
      miscompares++;
      complete_run();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Clear may delay counting by up to the clear pulse
  function automatic logic [31:0] near(input time t, input int exp);
    return 32'((t - t0) / 10 >= exp && (t - t0) / 10 <= exp + CLR_US * US + 20);
  endfunction
  task automatic wb(input logic w, input logic [3:0] m, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_sel_i, wb_adr_i, wb_dat_i} <= {2'h3, w, m, a, d};
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'h0;
    @(posedge clk_i);
  endtask
  task automatic complete_run();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // ----
  // Scenarios
  // ----
  task automatic t_regs();
    wb(1'b0, 4'hF, CTRL_ADDR, 32'h0, rd);
    chk(rd, 32'h6);
    wb(1'b0, 4'hF, 8'hFC, 32'h0, rd);
    chk(rd, 32'h0);
    wb(1'b1, 4'hF, CTRL_ADDR, 32'h7, rd);
    wb(1'b0, 4'hF, CTRL_ADDR, 32'h0, rd);
    chk(rd, 32'h7);
    // Low byte lane off: the control write must be ignored
    wb(1'b1, 4'hE, CTRL_ADDR, 32'h0, rd);
    wb(1'b0, 4'hF, CTRL_ADDR, 32'h0, rd);
    chk(rd, 32'h7);
    $display("test regs done");
  endtask
  task automatic t_sync_poll();
    @(posedge clk_i) cycle_sync_pulse_i <= 1'b1;
    t0 = $time + 10;
    @(posedge clk_i iff start_char_load_o);
    cycle_sync_pulse_i <= 1'b0;
    chk(32'(($time - t0) / 10 <= 5), 32'h1);
    chk(32'(cmd_mode_o), 32'h0);
    wb(1'b0, 4'hF, TIME_ADDR, 32'h0, rd);
    chk(rd, 32'h0);
    @(posedge clk_i iff poll_mode_o);
    chk(near($time, PST * US), 32'h1);
    @(posedge clk_i iff query_o);
    t1 = $time;
    sta = buffer_station_address_o;
    // A station answers; the next presentation carries its word
    mon_word_i <= 16'h5A3C;
    mon_valid_i <= 1'b1;
    @(posedge clk_i) mon_valid_i <= 1'b0;
    @(posedge clk_i iff mon_present_o);
    chk(32'(mon_out_o), 32'h5A3C0);
    @(posedge clk_i iff query_o);
    chk(32'(($time - t1) / 10), 32'(RESP_US * US));
    chk(32'(buffer_station_address_o), 32'(sta + 5'h1));
    // No answer this period, so the cleared buffer shows zero
    @(posedge clk_i iff mon_buf_clear_o);
    @(posedge clk_i iff mon_present_o);
    chk(32'(mon_out_o.word), 32'h0);
    $display("test sync and poll done");
  endtask
  task automatic t_cmd();
    @(posedge clk_i iff cmd_mode_o);
    chk(near($time, CST * US), 32'h1);
    for (int i = 0; i < 2; i++) begin
      @(posedge clk_i iff first_word_load_strobe_o);
      s = host_sel_o;
      if (i == 1) chk(32'(s != prev), 32'h1);
      prev = s;
      chk(32'(cmd_o.low_byte), s ? 32'hC3 : 32'h5A);
      @(posedge clk_i iff third_word_load_strobe_o);
      chk(32'({cmd_o.second, cmd_o.third}), s ? 32'h0F0FF0F0 : 32'h13572468);
      repeat (DL * 6) @(posedge clk_i);
      chk(32'(host_req_o[s]), 32'h0);
    end
    @(posedge clk_i iff !cmd_mode_o);
    chk(near($time, CEN * US), 32'h1);
    chk(32'(svc_int_o), 32'h1);
    @(posedge clk_i iff start_char_load_o);
    chk(near($time, BAT * US), 32'h1);
    $display("test command window done");
  endtask
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_sync_poll();
    t_cmd();
    complete_run();
  end
endmodule // tb
